// *** rtl/esr_sa_rx_status.sv ***
// Sa-bit receive status: capture bytes, sync messages, error counters,
// data-link vector masks and receive addresses, behind an AXI4-Lite slave.
// Assumes line inputs come from framer logic on aclk, so no synchronisers.
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/10ps

module esr_sa_rx_status (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [esr_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [esr_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire esr_pkg::esr_line_t line_in,
    input wire esr_pkg::esr_event_t events_in,
    output logic [15:0] link_vector,
    output logic [15:0] first_rx_address,
    output logic [15:0] second_rx_address
);
    import esr_pkg::*;

    typedef enum logic [1:0] {
        WR_IDLE = 2'b00,
        WR_RESP = 2'b01
    } esr_wr_state_t;

    // Bus slave state
    esr_wr_state_t wr_state_reg, wr_state_next;
    logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
    logic [5:0] aw_idx_reg, aw_idx_next;
    logic [31:0] w_data_reg, w_data_next;
    logic [3:0] w_strb_reg, w_strb_next;
    logic awready_reg, awready_next, wready_reg, wready_next;
    logic bvalid_reg, bvalid_next, arready_reg, arready_next;
    logic rvalid_reg, rvalid_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic [31:0] rdata_reg, rdata_next;
    logic wr_fire, rd_fire;
    logic [5:0] rd_idx;
    logic [15:0] wr_bits, wr_lane;

    // Software registers
    logic [15:0] mask_reg, mask_next, addr_low_reg, addr_low_next;
    logic [15:0] addr_high_reg, addr_high_next, ctrl_reg, ctrl_next;
    logic [15:0] valid_msg_reg, valid_msg_next, valid_err_reg, valid_err_next;

    // Capture and status state
    logic [7:0] shadow_reg [SA_COUNT];
    logic [7:0] shadow_next [SA_COUNT];
    logic [7:0] cap_reg [SA_COUNT];
    logic [7:0] cap_next [SA_COUNT];
    logic [3:0] nib_reg [SA_COUNT];
    logic [3:0] nib_next [SA_COUNT];
    logic [2:0] df_cnt_reg, df_cnt_next;
    logic spare_data_valid_reg, spare_data_valid_next;
    logic [3:0] last_nib_reg, last_nib_next, sync_pat_reg, sync_pat_next;
    logic [1:0] rep_reg, rep_next;
    logic sync_message_valid_reg, sync_message_valid_next;
    logic [15:0] cnt_reg [2];
    logic [15:0] cnt_next [2];
    logic [15:0] vec_reg, vec_next;

    // Derived line timing
    logic [2:0] bit_pos;
    logic byte_done, submf_done, sa_capture, sync_report;
    logic [3:0] msg_nib, err_nib;
    logic [2:0] msg_sel, err_sel;
    logic pattern_select, count_enable;
    logic [1:0] err_hit;

    assign pattern_select = ctrl_reg[CTL_PATTERN_SELECT];
    assign count_enable = ctrl_reg[CTL_COUNT_ENABLE];
    assign msg_sel = ctrl_reg[CTL_MSG_SRC_LSB +: 3];
    assign err_sel = ctrl_reg[CTL_ERR_SRC_LSB +: 3];

    // Bus handshakes and write lane merge
    assign wr_fire = aw_full_reg && w_full_reg && (wr_state_reg == WR_IDLE);
    assign rd_fire = s_axi_arvalid && arready_reg;
    assign rd_idx = s_axi_araddr[7:2];
    assign wr_bits = {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
    assign wr_lane = w_data_reg[15:0];

    // Write and read channels of the slave
    always_comb begin
        wr_state_next = wr_state_reg;
        aw_full_next = aw_full_reg;
        w_full_next = w_full_reg;
        aw_idx_next = aw_idx_reg;
        w_data_next = w_data_reg;
        w_strb_next = w_strb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        if (s_axi_awvalid && awready_reg) begin
            aw_full_next = 1'b1;
            aw_idx_next = s_axi_awaddr[7:2];
        end
        if (s_axi_wvalid && wready_reg) begin
            w_full_next = 1'b1;
            w_data_next = s_axi_wdata;
            w_strb_next = s_axi_wstrb;
        end
        case (wr_state_reg)
            WR_IDLE: begin
                if (wr_fire) begin
                    aw_full_next = 1'b0;
                    w_full_next = 1'b0;
                    bvalid_next = 1'b1;
                    wr_state_next = WR_RESP;
                    case (aw_idx_reg)
                        IDX_MASK, IDX_ADDR_LOW, IDX_ADDR_HIGH, IDX_SA_WORD1, IDX_SA_WORD2,
                        IDX_SA_WORD3, IDX_SYNC_MSG, IDX_ERR_CNT1, IDX_ERR_CNT2,
                        IDX_VALID_MSG, IDX_VALID_ERR, IDX_RX_CTRL: bresp_next = RESP_OKAY;
                        default: bresp_next = RESP_SLVERR;
                    endcase
                end
            end
            WR_RESP: begin
                if (s_axi_bready) begin
                    bvalid_next = 1'b0;
                    wr_state_next = WR_IDLE;
                end
            end
            default: wr_state_next = WR_IDLE;
        endcase
        // Ready only while the holding slot is free
        awready_next = !aw_full_next;
        wready_next = !w_full_next;
        rvalid_next = rvalid_reg;
        rresp_next = rresp_reg;
        rdata_next = rdata_reg;
        if (rd_fire) begin
            rvalid_next = 1'b1;
            rresp_next = RESP_OKAY;
            case (rd_idx)
                IDX_MASK: rdata_next = {16'h0000, mask_reg};
                IDX_ADDR_LOW: rdata_next = {16'h0000, addr_low_reg};
                IDX_ADDR_HIGH: rdata_next = {16'h0000, addr_high_reg};
                IDX_SA_WORD1: rdata_next = {16'h0000, cap_reg[1], cap_reg[0]};
                IDX_SA_WORD2: rdata_next = {16'h0000, cap_reg[3], cap_reg[2]};
                IDX_SA_WORD3: rdata_next = {23'h000000, spare_data_valid_reg, cap_reg[4]};
                IDX_SYNC_MSG: rdata_next = {24'h000000, sync_pat_reg, 3'h0, sync_message_valid_reg};
                IDX_ERR_CNT1: rdata_next = {16'h0000, cnt_reg[0]};
                IDX_ERR_CNT2: rdata_next = {16'h0000, cnt_reg[1]};
                IDX_VALID_MSG: rdata_next = {16'h0000, valid_msg_reg};
                IDX_VALID_ERR: rdata_next = {16'h0000, valid_err_reg};
                IDX_RX_CTRL: rdata_next = {16'h0000, ctrl_reg};
                default: begin
                    rdata_next = 32'h00000000;
                    rresp_next = RESP_SLVERR;
                end
            endcase
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
        arready_next = !rvalid_next;
    end

    // Writable registers; reserved bits stay zero
    always_comb begin
        mask_next = mask_reg;
        addr_low_next = addr_low_reg;
        addr_high_next = addr_high_reg;
        ctrl_next = ctrl_reg;
        valid_msg_next = valid_msg_reg;
        valid_err_next = valid_err_reg;
        if (wr_fire) begin
            case (aw_idx_reg)
                IDX_MASK: mask_next = ((mask_reg & ~wr_bits) | (wr_lane & wr_bits))
                    & MASK_WRITABLE;
                IDX_ADDR_LOW: addr_low_next = (addr_low_reg & ~wr_bits) | (wr_lane & wr_bits);
                IDX_ADDR_HIGH: addr_high_next = (addr_high_reg & ~wr_bits) | (wr_lane & wr_bits);
                IDX_RX_CTRL: ctrl_next = ((ctrl_reg & ~wr_bits) | (wr_lane & wr_bits))
                    & CTL_WRITABLE;
                IDX_VALID_MSG: valid_msg_next = (valid_msg_reg & ~wr_bits)
                    | (wr_lane & wr_bits);
                IDX_VALID_ERR: valid_err_next = (valid_err_reg & ~wr_bits)
                    | (wr_lane & wr_bits);
                default: mask_next = mask_reg;
            endcase
        end
    end

    // Bit position in the byte and sub-multiframe boundaries
    always_comb begin
        bit_pos = line_in.crc4_mode ? line_in.frame_num[3:1] : df_cnt_reg;
        byte_done = line_in.crc4_mode ? (line_in.frame_num == 4'hf) : (df_cnt_reg == 3'h7);
        submf_done = (bit_pos[1:0] == 2'h3);
        df_cnt_next = df_cnt_reg;
        if (line_in.frame_strobe) begin
            df_cnt_next = line_in.crc4_mode ? 3'h0 : df_cnt_reg + 3'h1;
        end
    end

    // Per Sa bit: byte assembly, held byte and nibble history
    genvar g;
    generate
        for (g = 0; g < SA_COUNT; g++) begin : g_sa
            always_comb begin
                shadow_next[g] = shadow_reg[g];
                nib_next[g] = nib_reg[g];
                cap_next[g] = cap_reg[g];
                if (line_in.frame_strobe) begin
                    shadow_next[g][bit_pos] = line_in.sa_bits[g];
                    nib_next[g] = {nib_reg[g][2:0], line_in.sa_bits[g]};
                    if (sa_capture) begin
                        cap_next[g] = shadow_next[g];
                    end
                end
            end
        end
    endgenerate

    // Capture is held off while unread data stands
    assign sa_capture = line_in.frame_strobe && byte_done && !spare_data_valid_reg;

    always_comb begin
        spare_data_valid_next = spare_data_valid_reg;
        if (rd_fire && rd_idx == IDX_SA_WORD3) begin
            spare_data_valid_next = 1'b0;
        end
        if (sa_capture) begin
            spare_data_valid_next = 1'b1;
        end
    end

    // Sync message: three identical nibbles in a row, then one report
    assign msg_nib = (msg_sel < 3'h5) ? nib_next[msg_sel] : nib_next[0];
    always_comb begin
        last_nib_next = last_nib_reg;
        rep_next = rep_reg;
        sync_report = 1'b0;
        if (line_in.frame_strobe && submf_done) begin
            last_nib_next = msg_nib;
            if (msg_nib != last_nib_reg || rep_reg == 2'h0) begin
                rep_next = 2'h1;
            end else if (rep_reg != SYNC_REPEATS) begin
                rep_next = rep_reg + 2'h1;
                // Fires once per run, not on every later repeat
                sync_report = (rep_next == SYNC_REPEATS)
                    && (!pattern_select || valid_msg_reg[msg_nib]);
            end
        end
        sync_pat_next = sync_report ? msg_nib : sync_pat_reg;
        sync_message_valid_next = sync_message_valid_reg;
        if (rd_fire && rd_idx == IDX_SYNC_MSG) begin
            sync_message_valid_next = 1'b0;
        end
        if (sync_report) begin
            sync_message_valid_next = 1'b1;
        end
    end

    // Error-indication match on the chosen Sa bit
    assign err_nib = (err_sel < 3'h5) ? nib_next[err_sel] : nib_next[0];
    always_comb begin
        if (pattern_select) begin
            err_hit[0] = (err_nib == valid_err_reg[3:0])
                || (err_nib == valid_err_reg[7:4]);
            err_hit[1] = (err_nib == valid_err_reg[11:8])
                || (err_nib == valid_err_reg[15:12]);
        end else begin
            err_hit[0] = (err_nib == ERR1_DEFAULT_A) || (err_nib == ERR1_DEFAULT_B);
            err_hit[1] = (err_nib == ERR2_DEFAULT_A) || (err_nib == ERR2_DEFAULT_B);
        end
    end

    // Two saturating counters, cleared by their read
    genvar c;
    generate
        for (c = 0; c < 2; c++) begin : g_cnt
            always_comb begin
                logic [15:0] base;
                logic bump;
                base = cnt_reg[c];
                bump = line_in.frame_strobe && submf_done && err_hit[c]
                    && line_in.mf_sync
                    && count_enable;
                if (rd_fire && rd_idx == (c == 0 ? IDX_ERR_CNT1 : IDX_ERR_CNT2)) begin
                    base = 16'h0000;
                end
                // Count lands after the clear so nothing is lost
                if (bump && base != ERR_CNT_SAT) begin
                    cnt_next[c] = base + 16'h0001;
                end else begin
                    cnt_next[c] = base;
                end
            end
        end
    endgenerate

    // Vector pulses gated by the mask; the pin scheme lives elsewhere
    always_comb begin
        vec_next = 16'h0000;
        vec_next[BIT_TX_SPARE_SENT] = events_in.tx_spare_sent;
        vec_next[BIT_EVERYTHING_SENT] = events_in.everything_sent;
        vec_next[BIT_TX_UNDERRUN] = events_in.tx_underrun;
        vec_next[BIT_TX_POOL_READY] = events_in.tx_pool_ready;
        vec_next[BIT_RX_SPARE_VALID] = sa_capture;
        vec_next[BIT_SYNC_MSG] = sync_report;
        vec_next[BIT_RX_POOL_FULL] = events_in.rx_pool_full;
        vec_next[BIT_RX_MSG_END] = events_in.rx_message_end;
        vec_next[BIT_BAD_SYNC_FORMAT] = events_in.bad_sync_format;
        vec_next = vec_next & ~mask_reg;
    end

    // All state registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_reg <= WR_IDLE;
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            aw_idx_reg <= 6'h00;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rresp_reg <= RESP_OKAY;
            rdata_reg <= 32'h00000000;
            mask_reg <= REG_RESET;
            addr_low_reg <= REG_RESET;
            addr_high_reg <= REG_RESET;
            ctrl_reg <= REG_RESET;
            valid_msg_reg <= REG_RESET;
            valid_err_reg <= REG_RESET;
            for (int i = 0; i < SA_COUNT; i++) begin
                shadow_reg[i] <= 8'h00;
                cap_reg[i] <= 8'h00;
                nib_reg[i] <= 4'h0;
            end
            df_cnt_reg <= 3'h0;
            spare_data_valid_reg <= 1'b0;
            last_nib_reg <= 4'h0;
            sync_pat_reg <= 4'h0;
            rep_reg <= 2'h0;
            sync_message_valid_reg <= 1'b0;
            cnt_reg[0] <= REG_RESET;
            cnt_reg[1] <= REG_RESET;
            vec_reg <= 16'h0000;
        end else begin
            wr_state_reg <= wr_state_next;
            aw_full_reg <= aw_full_next;
            w_full_reg <= w_full_next;
            aw_idx_reg <= aw_idx_next;
            w_data_reg <= w_data_next;
            w_strb_reg <= w_strb_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
            mask_reg <= mask_next;
            addr_low_reg <= addr_low_next;
            addr_high_reg <= addr_high_next;
            ctrl_reg <= ctrl_next;
            valid_msg_reg <= valid_msg_next;
            valid_err_reg <= valid_err_next;
            for (int i = 0; i < SA_COUNT; i++) begin
                shadow_reg[i] <= shadow_next[i];
                cap_reg[i] <= cap_next[i];
                nib_reg[i] <= nib_next[i];
            end
            df_cnt_reg <= df_cnt_next;
            spare_data_valid_reg <= spare_data_valid_next;
            last_nib_reg <= last_nib_next;
            sync_pat_reg <= sync_pat_next;
            rep_reg <= rep_next;
            sync_message_valid_reg <= sync_message_valid_next;
            cnt_reg[0] <= cnt_next[0];
            cnt_reg[1] <= cnt_next[1];
            vec_reg <= vec_next;
        end
    end

    // Outputs straight from flops
    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;
    assign link_vector = vec_reg;
    assign first_rx_address = {addr_high_reg[7:0], addr_low_reg[7:0]};
    assign second_rx_address = {addr_high_reg[15:8], addr_low_reg[15:8]};

endmodule // esr_sa_rx_status

// *** rtl/esr_pkg.sv ***
// Shared constants and carriers for the E1 spare-bit receive status block.
// Assumes a single 25 MHz clock and a framer that marks each Sa-carrying frame.
package esr_pkg;

    // Register indices; the byte address is four times the index
    localparam logic [5:0] IDX_MASK = 6'h08;
    localparam logic [5:0] IDX_ADDR_LOW = 6'h09;
    localparam logic [5:0] IDX_ADDR_HIGH = 6'h0a;
    localparam logic [5:0] IDX_SA_WORD1 = 6'h0b;
    localparam logic [5:0] IDX_SA_WORD2 = 6'h0c;
    localparam logic [5:0] IDX_SA_WORD3 = 6'h0d;
    localparam logic [5:0] IDX_SYNC_MSG = 6'h0e;
    localparam logic [5:0] IDX_ERR_CNT1 = 6'h0f;
    localparam logic [5:0] IDX_ERR_CNT2 = 6'h10;
    localparam logic [5:0] IDX_VALID_MSG = 6'h14;
    localparam logic [5:0] IDX_VALID_ERR = 6'h15;
    localparam logic [5:0] IDX_RX_CTRL = 6'h20;
    localparam int ADDR_W = 8;

    // Reset value shared by every register
    localparam logic [15:0] REG_RESET = 16'h0000;
    // Writable bits of the mask register
    localparam logic [15:0] MASK_WRITABLE = 16'h0f1f;

    // Mask and vector bit positions
    localparam int BIT_TX_SPARE_SENT = 11;
    localparam int BIT_EVERYTHING_SENT = 10;
    localparam int BIT_TX_UNDERRUN = 9;
    localparam int BIT_TX_POOL_READY = 8;
    localparam int BIT_RX_SPARE_VALID = 4;
    localparam int BIT_SYNC_MSG = 3;
    localparam int BIT_RX_POOL_FULL = 2;
    localparam int BIT_RX_MSG_END = 1;
    localparam int BIT_BAD_SYNC_FORMAT = 0;

    // Field positions of the receive control register
    localparam int CTL_PATTERN_SELECT = 0;
    localparam int CTL_MSG_SRC_LSB = 1;
    localparam int CTL_COUNT_ENABLE = 4;
    localparam int CTL_ERR_SRC_LSB = 5;
    localparam logic [15:0] CTL_WRITABLE = 16'h00ff;

    // Other field positions
    localparam int SA_VALID_BIT = 8;
    localparam int SYNC_PATTERN_LSB = 4;
    localparam int SYNC_VALID_BIT = 0;

    // Error-indication patterns used while pattern select is 0
    localparam logic [3:0] ERR1_DEFAULT_A = 4'h1;
    localparam logic [3:0] ERR1_DEFAULT_B = 4'h3;
    localparam logic [3:0] ERR2_DEFAULT_A = 4'h2;
    localparam logic [3:0] ERR2_DEFAULT_B = 4'h3;
    localparam logic [15:0] ERR_CNT_SAT = 16'h0fff;
    localparam logic [1:0] SYNC_REPEATS = 2'h3;
    localparam int SA_COUNT = 5;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // One Sa-carrying frame from the framer, same clock domain
    typedef struct packed {
        logic frame_strobe;     // One-cycle pulse per Sa-carrying frame
        logic [4:0] sa_bits;    // Bit 0 is Sa4, bit 4 is Sa8
        logic [3:0] frame_num;  // Frame number within the multiframe
        logic crc4_mode;        // 1: CRC-4 multiframe, 0: doubleframe
        logic mf_sync;          // Multiframe synchronous state
    } esr_line_t;

    // Data link event pulses made elsewhere in the framer
    typedef struct packed {
        logic tx_spare_sent;
        logic everything_sent;
        logic tx_underrun;
        logic tx_pool_ready;
        logic rx_pool_full;
        logic rx_message_end;
        logic bad_sync_format;
    } esr_event_t;

endpackage

// *** verification/esr_sa_rx_status_props.sv ***
// Port checker for the spare-bit receive status block.
// Assumes it is bound onto esr_sa_rx_status; one aclk domain.
`timescale 1ns/10ps
module esr_sa_rx_status_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_bvalid,
    input wire esr_pkg::esr_line_t line_in,
    input wire esr_pkg::esr_event_t events_in,
    input wire logic [15:0] link_vector,
    input wire logic [15:0] first_rx_address,
    input wire logic [15:0] second_rx_address
);
    import esr_pkg::*;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Every vector bit needs its own cause one cycle earlier
    AST_UNUSED_VEC_ZERO: assert property ({link_vector[15:12], link_vector[7:5]} == 7'h00)
        else $error("unused vector bit set");
    AST_TX_VEC_CAUSE: assert property ((link_vector[11:8] & ~$past(events_in[6:3])) == '0)
        else $error("transmit vector without event");
    AST_RX_VEC_CAUSE: assert property ((link_vector[2:0] & ~$past(events_in[2:0])) == '0)
        else $error("receive vector without event");
    AST_SA_VEC_CAUSE: assert property (link_vector[4] |-> $past(line_in.frame_strobe) &&
        (!$past(line_in.crc4_mode) || $past(line_in.frame_num) == 4'hf))
        else $error("capture vector off the multiframe end");
    AST_SA_VEC_SINGLE: assert property (link_vector[4] |=> (!link_vector[4]) [*8])
        else $error("capture vector repeated");
    AST_SYNC_VEC_CAUSE: assert property (link_vector[3] |-> $past(line_in.frame_strobe) &&
        (!$past(line_in.crc4_mode) || $past(line_in.frame_num[2:1]) == 2'b11))
        else $error("sync vector off a submultiframe end");
    AST_SYNC_VEC_SINGLE: assert property (link_vector[3] |=> (!link_vector[3]) [*8])
        else $error("sync vector repeated");
    // Address outputs only move with a completed write
    AST_ADDR_ON_WRITE: assert property (
        !$stable({first_rx_address, second_rx_address}) |-> $rose(s_axi_bvalid))
        else $error("address changed without a write");
    cover property (link_vector[4]);
    cover property (link_vector[3]);
    cover property ($rose(s_axi_bvalid));
endmodule // esr_sa_rx_status_props

// *** verification/esr_line_model.sv ***
// Remote E1 line model: one multiframe of Sa bits per call, CRC-4 or doubleframe.
// Assumes the bench calls send_mf; frames are two aclk cycles apart.
`timescale 1ns/10ps
module esr_line_model (
    input wire logic aclk,
    output esr_pkg::esr_line_t line_out
);
    import esr_pkg::*;
    initial line_out = 12'h002;
    // Odd frames 1..15 carry bit i of each byte; b is {Sa8,Sa7,Sa6,Sa5,Sa4}
    // cm 0 sends the same eight bits per byte as doubleframes
    task automatic send_mf(input logic [39:0] b, input logic ms, input logic cm = 1'b1);
        logic [4:0] s;
        for (int i = 0; i < 8; i++) begin
            s = {b[32+i], b[24+i], b[16+i], b[8+i], b[i]};
            @(posedge aclk);
            line_out.frame_strobe <= 1'b1;
            line_out.frame_num <= 4'(2 * i + 1);
            line_out.sa_bits <= s;
            line_out.mf_sync <= ms;
            line_out.crc4_mode <= cm;
            @(posedge aclk);
            line_out.frame_strobe <= 1'b0;
            line_out.sa_bits <= ~s; // Stale bits inverted so they cannot pass
        end
    endtask
endmodule // esr_line_model

// *** verification/esr_sa_rx_status_tb.sv ***
// Self-checking bench for the spare-bit receive status block.
// Assumes the line model and the bound port checker.
`timescale 1ns/10ps
module esr_sa_rx_status_tb;
    import esr_pkg::*;
    // Response channels stay ready, so back-to-back calls never drop and raise them at one edge
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1;
    logic s_axi_arvalid = 0, s_axi_rready = 1, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    esr_line_t line_in;
    esr_event_t events_in = 7'h00;
    logic [15:0] link_vector, first_rx_address, second_rx_address;
    int num_errors = 0, n_compared = 0;
    always #20 aclk = ~aclk;
    esr_sa_rx_status uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .line_in, .events_in, .link_vector,
        .first_rx_address, .second_rx_address);
    esr_line_model src (.aclk, .line_out(line_in));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Address and data offered together; each dropped once taken
    task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!(s_axi_bvalid && s_axi_bready));
        chk({30'h0, s_axi_bresp}, {30'h0, er});
    endtask
    // Read, then compare masked data and the response
    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1,
        input logic [1:0] er = 2'h0);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!(s_axi_rvalid && s_axi_rready));
        chk(s_axi_rdata & m, e);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
    endtask
    // Reset values, read-only word, unmapped place, address placement
    task automatic t_regs();
        for (int i = 8; i <= 16; i++) rdc(8'(i * 4), 32'h0);
        wrc(8'h2c, 32'hffff);
        rdc(8'h2c, 32'h0);
        wrc(8'h20, 32'hffff_ffff);
        rdc(8'h20, 32'h0f1f);
        wrc(8'hfc, 32'h1, RESP_SLVERR);
        rdc(8'hfc, 32'h0, '1, RESP_SLVERR);
        wrc(8'h24, 32'h2211);
        wrc(8'h28, 32'h4433);
        chk({16'h0, first_rx_address}, 32'h3311);
        chk({16'h0, second_rx_address}, 32'h4422);
        rdc(8'h28, 32'h4433);
    endtask
    // All events masked, then all unmasked
    task automatic t_mask();
        for (int k = 0; k < 2; k++) begin
            wrc(8'h20, k ? 32'h0 : 32'h0f1f);
            @(posedge aclk);
            events_in <= 7'h7f;
            @(posedge aclk);
            events_in <= 7'h00;
            @(posedge aclk);
            chk({16'h0, link_vector}, k ? 32'h0f07 : 32'h0);
        end
    endtask
    // Capture, hold while valid, sync report, counts, sync-state gate
    task automatic t_sa();
        wrc(8'h80, 32'h10);
        src.send_mf(40'ha5_3c_c3_5a_88, 1'b1);
        src.send_mf(40'h44_33_22_11_88, 1'b1);
        rdc(8'h2c, 32'h5a88);
        rdc(8'h30, 32'h3cc3);
        rdc(8'h34, 32'h01a5);
        rdc(8'h34, 32'h00a5);
        rdc(8'h38, 32'h0011);
        rdc(8'h38, 32'h0, 32'h1);
        rdc(8'h3c, 32'h4);
        rdc(8'h40, 32'h0);
        rdc(8'h3c, 32'h0);
        src.send_mf(40'h44_33_22_11_88, 1'b0);
        rdc(8'h2c, 32'h1188);
        rdc(8'h3c, 32'h0);
        src.send_mf(40'h00_00_00_00_4c, 1'b1);
        rdc(8'h3c, 32'h1);
        rdc(8'h40, 32'h2);
    endtask
    // 2049 multiframes carry 4098 indications, past the stop value
    task automatic t_sat();
        repeat (2049) src.send_mf(40'h0_88, 1'b1);
        rdc(8'h3c, 32'h0fff);
    endtask
    // Programmed patterns on Sa5, pattern filter, one doubleframe byte
    task automatic t_pat();
        wrc(8'h50, 32'h20);
        wrc(8'h54, 32'haaa5);
        wrc(8'h80, 32'h33);
        rdc(8'h38, 32'h11);
        repeat (2) src.send_mf(40'h5500, 1'b1);
        rdc(8'h38, 32'h0, 32'h1);
        rdc(8'h34, 32'h0144);
        src.send_mf(40'h81_0000_aa00, 1'b1, 1'b0);
        src.send_mf(40'haa00, 1'b1);
        rdc(8'h38, 32'h51);
        rdc(8'h34, 32'h0181);
        rdc(8'h3c, 32'h8);
        rdc(8'h40, 32'h4);
    endtask
    task automatic give_verdict();
        if (num_errors == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_regs();
        t_mask();
        t_sa();
        t_sat();
        t_pat();
        give_verdict();
    end
    // Run needs about 35k cycles; stop well past that
    initial begin
        #2_400_000;
        num_errors++;
        give_verdict();
    end
endmodule // esr_sa_rx_status_tb
bind esr_sa_rx_status esr_sa_rx_status_props chk_i (.aclk, .aresetn, .s_axi_bvalid, .line_in,
    .events_in, .link_vector, .first_rx_address, .second_rx_address);
